/* hdl/dte_engine.sv */
// Notes on behaviour
// [R1] The discard limit is 2^15 clocks, or 2^10 when bridge control bit 9 is set.
// [R2] A completed delayed transaction counts clocks while waiting for the repeat.
// [R3] When that count expires the held status and data are thrown away.
// [R4] A held prefetchable read may be dropped when software allows it.
// [R5] As target the first data phase answers within 16 clocks of the request.
// [R6] An access that would run past 16 clocks is captured and answered with retry.
// [R7] The initiator ends on retry and later repeats the identical request.
// [R8] A captured request is run on the destination side and its result kept.
// [R9] The kept result waits until the initiator repeats, unless discarded.
// [R10] A matching repeat gets the kept status and read data, ending the entry.
// [R11] Any request that does not match the held one is retried again.
// [R12] With diagnostic control bit 2 clear, delayed requests retry at once.
// [R13] Only one delayed transaction is tracked per direction.
// [R14] The initiator rearbitrates and reissues to collect a completion.
// [R15] A destination timeout on a delayed write raises a system error unless bit 5 disables it.
// [R16] A destination timeout on a delayed read raises a system error unless bit 6 disables it.
// [R17] The discard count starts at completion and clears when the slot frees.
module dte_engine #(
    parameter int unsigned DISCARD_LONG = dte_pkg::DISCARD_LONG_CLKS
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    // register bus
    input  wire logic [dte_pkg::AV_AW-1:0] address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic [31:0]                    readdata,
    output logic                           waitrequest,
    // initiating side, index 0 downstream, 1 upstream
    input  wire logic [1:0]                ini_valid,
    input  wire dte_pkg::dte_req_t [1:0]   ini_req,
    output logic [1:0]                     ini_retry,
    output logic [1:0]                     ini_done,
    output dte_pkg::dte_rsp_t [1:0]        ini_rsp,
    // destination side
    output logic [1:0]                     dst_valid,
    output dte_pkg::dte_req_t [1:0]        dst_req,
    input  wire logic [1:0]                dst_ack,
    input  wire dte_pkg::dte_rsp_t [1:0]   dst_rsp,
    input  wire logic [1:0]                dst_timeout,
    // events
    output logic                           primary_system_error_event,
    output logic                           irq
);
    import dte_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************

    // merge write data into a register under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // mask of bits a write-one-to-clear access hits
    function automatic logic [7:0] w1c_mask(input logic hit,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        return (hit && be[0]) ? wd[7:0] : 8'h00;
    endfunction

    // ************************************************************
    // register bus slave
    // ************************************************************
    logic        wr_en;
    logic [7:0]  idx;
    logic [31:0] rd_mux;

    dte_avmm_slave u_bus (
        .clk         (clk),
        .rst         (rst),
        .read        (read),
        .write       (write),
        .address     (address),
        .rd_data     (rd_mux),
        .waitrequest (waitrequest),
        .readdata    (readdata),
        .wr_en       (wr_en),
        .idx         (idx)
    );

    logic [15:0] bridge_ctrl;
    logic [15:0] diag_ctrl;
    logic [7:0]  serr_dis;
    logic [7:0]  serr_stat;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [31:0] pf_base;
    logic [31:0] pf_limit;
    logic        pf_ctrl;
    logic [3:0]  slot_stat;

    // write decode
    wire wr_bctrl = wr_en && (idx == REG_BRIDGE_CTRL);
    wire wr_dctrl = wr_en && (idx == REG_DIAG_CTRL);
    wire wr_sdis  = wr_en && (idx == REG_SERR_DIS);
    wire wr_sstat = wr_en && (idx == REG_SERR_STAT);
    wire wr_iclr  = wr_en && (idx == REG_IRQ_CLR);
    wire wr_ien   = wr_en && (idx == REG_IRQ_EN);
    wire wr_pfb   = wr_en && (idx == REG_PF_BASE);
    wire wr_pfl   = wr_en && (idx == REG_PF_LIMIT);
    wire wr_pfc   = wr_en && (idx == REG_PF_CTRL);

    // read mux, unmapped and write-only indices read zero
    assign rd_mux =
        (idx == REG_BRIDGE_CTRL) ? {16'h0000, bridge_ctrl} :
        (idx == REG_DIAG_CTRL)   ? {16'h0000, diag_ctrl} :
        (idx == REG_SERR_DIS)    ? {24'h000000, serr_dis} :
        (idx == REG_SERR_STAT)   ? {24'h000000, serr_stat} :
        (idx == REG_IRQ_STAT)    ? {28'h0000000, irq_stat} :
        (idx == REG_IRQ_EN)      ? {28'h0000000, irq_en} :
        (idx == REG_SLOT_STAT)   ? {28'h0000000, slot_stat} :
        (idx == REG_PF_BASE)     ? pf_base :
        (idx == REG_PF_LIMIT)    ? pf_limit :
        (idx == REG_PF_CTRL)     ? {31'h00000000, pf_ctrl} :
                                   32'h0000_0000;

    // control fields that steer the slots
    // [R1] discard length select
    wire discard_short = bridge_ctrl[BC_DISCARD_SHORT];
    // [R12] immediate retry when clear
    wire delay_en      = diag_ctrl[DC_DELAY_EN];
    wire pf_drop_en    = pf_ctrl;

    // ************************************************************
    // per-direction delayed transaction slots
    // ************************************************************
    logic [1:0] disc_ev;
    logic [1:0] tmo_wr;
    logic [1:0] tmo_rd;

    for (genvar d = 0; d < 2; d++) begin : g_dir
        dte_state_t  state;
        dte_state_t  next_state;
        dte_req_t    held;
        dte_rsp_t    comp;
        logic [TW_W-1:0] wait_cnt;
        logic        tmr_exp;
        logic        capture;
        logic        retry_now;
        logic        done_run;
        logic        done_held;
        logic        drop_pf;

        // [R10] exact compare of address, command and byte enables
        wire hit = ini_valid[d] && (ini_req[d].addr == held.addr)
                   && (ini_req[d].cmd == held.cmd)
                   && (ini_req[d].be == held.be);
        wire in_pf = (held.addr >= pf_base) && (held.addr <= pf_limit);
        // [R4] reads that are prefetchable by range or by command
        wire pf_read = !dte_is_write(held.cmd)
                       && (in_pf || held.cmd == CMD_MEM_RD_LINE
                           || held.cmd == CMD_MEM_RD_MULT);
        wire lost = (state == ST_RUN || state == ST_PEND) && dst_timeout[d];

        // [R2] discard count runs only while a completion is held
        dte_discard_timer #(
            .LONG_CLKS (DISCARD_LONG)
        ) u_tmr (
            .clk       (clk),
            .rst       (rst),
            .run       (state == ST_HELD),
            .short_sel (discard_short),
            .expired   (tmr_exp)
        );

        // slot sequencing; a repeat that lands on the expiry clock still wins
        always_comb begin
            next_state = state;
            capture    = 1'b0;
            retry_now  = 1'b0;
            done_run   = 1'b0;
            done_held  = 1'b0;
            drop_pf    = 1'b0;
            unique case (state)
                ST_IDLE: begin
                    // [R6] capture request fields
                    if (ini_valid[d]) begin
                        capture    = 1'b1;
                        retry_now  = !delay_en;
                        next_state = delay_en ? ST_RUN : ST_PEND;
                    end
                end
                ST_RUN: begin
                    if (dst_timeout[d]) begin
                        retry_now  = 1'b1;
                        next_state = ST_IDLE;
                    end else if (dst_ack[d]) begin
                        done_run   = 1'b1;
                        next_state = ST_IDLE;
                    // [R5] retry before 16 clocks pass
                    end else if (wait_cnt == TW_W'(RETRY_AT)) begin
                        retry_now  = 1'b1;
                        next_state = ST_PEND;
                    end
                end
                ST_PEND: begin
                    // [R11] nothing to give back yet
                    retry_now = ini_valid[d];
                    if (dst_timeout[d]) begin
                        next_state = ST_IDLE;
                    // [R8] completion recorded
                    end else if (dst_ack[d]) begin
                        next_state = ST_HELD;
                    end
                end
                ST_HELD: begin
                    // [R11] mismatch retried
                    retry_now = ini_valid[d] && !hit;
                    // [R9] held until a match, expiry or drop
                    if (hit) begin
                        done_held  = 1'b1;
                        next_state = ST_IDLE;
                    // [R3] stale completion dropped
                    end else if (tmr_exp) begin
                        next_state = ST_IDLE;
                    end else if (ini_valid[d]) begin
                        // [R4] optional early drop
                        drop_pf    = pf_drop_en && pf_read;
                        next_state = drop_pf ? ST_IDLE : ST_HELD;
                    end
                end
            endcase
        end

        // [R13] one state register per direction
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                state <= ST_IDLE;
            end else begin
                state <= next_state;
            end
        end

        // first-phase clock count
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                wait_cnt <= '0;
            end else begin
                wait_cnt <= (state == ST_RUN) ? wait_cnt + 1'b1 : '0;
            end
        end

        // captured request and recorded completion
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                held <= '0;
                comp <= '0;
            end else begin
                held <= capture ? ini_req[d] : held;
                comp <= (state == ST_PEND && dst_ack[d]) ? dst_rsp[d] : comp;
            end
        end

        // [R8] destination request held until answered
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                dst_valid[d] <= 1'b0;
            end else if (capture) begin
                dst_valid[d] <= 1'b1;
            end else if (dst_ack[d] || dst_timeout[d]) begin
                dst_valid[d] <= 1'b0;
            end
        end

        // registered answers to the initiator
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                ini_retry[d] <= 1'b0;
                ini_done[d]  <= 1'b0;
                ini_rsp[d]   <= '0;
            end else begin
                ini_retry[d] <= retry_now;
                // [R10] status and data handed back
                ini_done[d]  <= done_run || done_held;
                ini_rsp[d]   <= done_run ? dst_rsp[d]
                              : done_held ? comp : ini_rsp[d];
            end
        end

        assign dst_req[d] = held;
        // [R17] slot freed on expiry or drop
        assign disc_ev[d] = (state == ST_HELD && tmr_exp && !hit) || drop_pf;
        assign tmo_wr[d]  = lost && dte_is_write(held.cmd);
        assign tmo_rd[d]  = lost && !dte_is_write(held.cmd);
        assign slot_stat[2*d +: 2] = state;
    end

    // ************************************************************
    // system error and interrupt events
    // ************************************************************
    // [R15] write timeout gated by disable bit
    wire serr_dw = (|tmo_wr) && !serr_dis[SE_DW_TMO];
    // [R16] read timeout gated by disable bit
    wire serr_dr = (|tmo_rd) && !serr_dis[SE_DR_TMO];

    logic [7:0] serr_set;
    always_comb begin
        serr_set            = 8'h00;
        serr_set[SE_DW_TMO] = serr_dw;
        serr_set[SE_DR_TMO] = serr_dr;
    end

    wire [7:0] serr_clr = w1c_mask(wr_sstat, writedata, byteenable);
    wire [7:0] irq_clr  = w1c_mask(wr_iclr, writedata, byteenable);
    wire [3:0] irq_set  = {tmo_wr | tmo_rd, disc_ev};

    // sticky status: a set on the clear clock survives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serr_stat <= 8'h00;
            irq_stat  <= 4'h0;
            primary_system_error_event <= 1'b0;
        end else begin
            serr_stat <= (serr_stat & ~serr_clr) | serr_set;
            irq_stat  <= (irq_stat & ~irq_clr[3:0]) | irq_set;
            primary_system_error_event <= serr_dw || serr_dr;
        end
    end

    // level interrupt from enabled sticky bits
    assign irq = |(irq_stat & irq_en);

    // ************************************************************
    // software control registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bridge_ctrl <= BRIDGE_CTRL_RST;
            diag_ctrl   <= DIAG_CTRL_RST;
            serr_dis    <= SERR_DIS_RST;
        end else begin
            bridge_ctrl <= wr_bctrl ? 16'(be_merge({16'h0000, bridge_ctrl},
                               writedata, byteenable)) : bridge_ctrl;
            diag_ctrl   <= wr_dctrl ? 16'(be_merge({16'h0000, diag_ctrl},
                               writedata, byteenable)) : diag_ctrl;
            serr_dis    <= wr_sdis ? 8'(be_merge({24'h000000, serr_dis},
                               writedata, byteenable)) : serr_dis;
        end
    end

    // prefetch window and interrupt enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pf_base  <= 32'h0000_0000;
            pf_limit <= 32'h0000_0000;
            pf_ctrl  <= 1'b0;
            irq_en   <= 4'h0;
        end else begin
            pf_base  <= wr_pfb ? be_merge(pf_base, writedata, byteenable) : pf_base;
            pf_limit <= wr_pfl ? be_merge(pf_limit, writedata, byteenable) : pf_limit;
            pf_ctrl  <= (wr_pfc && byteenable[0]) ? writedata[PF_DROP_EN] : pf_ctrl;
            irq_en   <= (wr_ien && byteenable[0]) ? writedata[3:0] : irq_en;
        end
    end

endmodule // dte_engine

/* hdl/dte_pkg.sv */
package dte_pkg;

    // ************************************************************
    // timing, counted in bus clocks
    // ************************************************************
    localparam int unsigned TGT_FIRST_CLKS     = 16;
    // answer pulse is registered, so decide two clocks early
    localparam int unsigned RETRY_AT           = TGT_FIRST_CLKS - 2;
    localparam int unsigned DISCARD_SHORT_CLKS = 1024;
    localparam int unsigned DISCARD_LONG_CLKS  = 32768;
    localparam int unsigned DT_W               = 16;
    localparam int unsigned TW_W               = 5;

    // ************************************************************
    // register map: indices, byte address is four times the index
    // ************************************************************
    localparam int unsigned AV_AW          = 10;
    localparam logic [7:0]  REG_BRIDGE_CTRL = 8'h3e;
    localparam logic [7:0]  REG_DIAG_CTRL   = 8'h5c;
    localparam logic [7:0]  REG_SERR_DIS    = 8'h64;
    localparam logic [7:0]  REG_SERR_STAT   = 8'h6a;
    localparam logic [7:0]  REG_IRQ_STAT    = 8'h70;
    localparam logic [7:0]  REG_IRQ_CLR     = 8'h71;
    localparam logic [7:0]  REG_IRQ_EN      = 8'h72;
    localparam logic [7:0]  REG_SLOT_STAT   = 8'h73;
    localparam logic [7:0]  REG_PF_BASE     = 8'h74;
    localparam logic [7:0]  REG_PF_LIMIT    = 8'h75;
    localparam logic [7:0]  REG_PF_CTRL     = 8'h76;

    // field positions
    localparam int unsigned BC_DISCARD_SHORT = 9;
    localparam int unsigned DC_DELAY_EN      = 2;
    localparam int unsigned SE_DW_TMO        = 5;
    localparam int unsigned SE_DR_TMO        = 6;
    localparam int unsigned PF_DROP_EN       = 0;
    localparam int unsigned IRQ_DISCARD      = 0;
    localparam int unsigned IRQ_TMO          = 2;

    // reset values
    localparam logic [15:0] BRIDGE_CTRL_RST = 16'h0000;
    localparam logic [15:0] DIAG_CTRL_RST   = 16'h0000;
    localparam logic [7:0]  SERR_DIS_RST    = 8'h00;

    // command codes that imply prefetchable memory, and the master abort status code
    localparam logic [3:0]  CMD_MEM_RD_MULT = 4'hc;
    localparam logic [3:0]  CMD_MEM_RD_LINE = 4'he;
    localparam logic [1:0]  CS_MASTER_ABORT = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_PEND = 2'b10,
        ST_HELD = 2'b11
    } dte_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic [3:0]  be;
        logic [31:0] wdata;
    } dte_req_t;

    typedef struct packed {
        logic [1:0]  status;
        logic [31:0] rdata;
    } dte_rsp_t;

    // odd command codes are writes
    function automatic logic dte_is_write(input logic [3:0] cmd);
        return cmd[0];
    endfunction

endpackage

/* hdl/dte_discard_timer.sv */
module dte_discard_timer #(
    parameter int unsigned LONG_CLKS = dte_pkg::DISCARD_LONG_CLKS
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic short_sel,
    output logic      expired
);
    import dte_pkg::*;

    logic [DT_W-1:0] count;
    wire  [DT_W-1:0] limit = short_sel ? DT_W'(DISCARD_SHORT_CLKS - 1)
                                       : DT_W'(LONG_CLKS - 1);

    // one-clock pulse on the last counted clock
    assign expired = run && (count >= limit);

    // idle timer sits at zero so a new completion starts clean
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (!run || expired) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule // dte_discard_timer

/* hdl/dte_avmm_slave.sv */
module dte_avmm_slave (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [dte_pkg::AV_AW-1:0] address,
    input  wire logic [31:0]               rd_data,
    output logic                           waitrequest,
    output logic [31:0]                    readdata,
    output logic                           wr_en,
    output logic [7:0]                     idx
);
    import dte_pkg::*;

    logic ack;

    // exactly one wait state per access
    assign waitrequest = (read || write) && !ack;
    assign wr_en       = write && ack;
    assign idx         = address[AV_AW-1:2];

    // read data caught while the address is held, valid on the ack clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack      <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack      <= (read || write) && !ack;
            readdata <= (read && !ack) ? rd_data : readdata;
        end
    end

endmodule // dte_avmm_slave

/* verif/dte_props.sv */
module dte_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    input wire logic [1:0] ini_valid,
    input wire logic [1:0] ini_retry,
    input wire logic [1:0] ini_done,
    input wire logic [1:0] dst_valid,
    input wire logic [1:0] dst_ack,
    input wire logic [1:0] dst_timeout,
    input wire logic       primary_system_error_event
);
    import dte_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // one wait state, then the answer
    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    a_bus_one_wait: assert property ($rose(read || write) |-> s_one_wait)
        else $error("bus wait state wrong");
    a_answer_bound: assert property (ini_valid[0] |-> ##[1:16] (ini_retry[0] || ini_done[0]))
        else $error("no answer within 16 clocks");
    a_answer_excl: assert property ((ini_retry & ini_done) == 2'b00)
        else $error("retry and done together");
    a_dst_launch: assert property ($rose(dst_valid[0]) |-> $past(ini_valid[0]))
        else $error("destination start without request");
    a_dst_release: assert property (dst_valid[0] && (dst_ack[0] || dst_timeout[0])
        |=> !dst_valid[0])
        else $error("destination request not ended");
    a_retry_pulse: assert property (ini_retry[0] |=> !ini_retry[0])
        else $error("retry longer than one clock");
    a_serr_cause: assert property (primary_system_error_event |-> |$past(dst_timeout))
        else $error("system error without timeout");
    a_serr_pulse: assert property (primary_system_error_event |=> !primary_system_error_event)
        else $error("system error longer than one clock");
    a_up_done: assert property (ini_done[1] |-> $past(ini_valid[1] || dst_ack[1]))
        else $error("upstream done without request");
endmodule // dte_props

bind dte_engine dte_props u_props (.*);

/* verif/dte_dst_model.sv */
module dte_dst_model (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [1:0]              dst_valid,
    input  wire dte_pkg::dte_req_t [1:0] dst_req,
    input  wire logic [7:0]              lat,
    input  wire logic                    tmo,
    output logic [1:0]                   dst_ack,
    output logic [1:0]                   dst_timeout,
    output dte_pkg::dte_rsp_t [1:0]      dst_rsp
);
    import dte_pkg::*;
    logic [7:0] cnt [2];
    // answer after lat clocks, or a timeout on command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '{8'h00, 8'h00};
            dst_ack <= 2'b00;
            dst_timeout <= 2'b00;
            dst_rsp <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // idle data toggles so stale values never look valid
                dst_rsp[i].rdata <= ~dst_rsp[i].rdata;
                dst_ack[i] <= 1'b0;
                dst_timeout[i] <= 1'b0;
                cnt[i] <= dst_valid[i] && !dst_ack[i] && !dst_timeout[i] ? cnt[i] + 8'h01 : 8'h00;
                if (dst_valid[i] && cnt[i] == lat) begin
                    dst_ack[i] <= !tmo;
                    dst_timeout[i] <= tmo;
                    dst_rsp[i] <= '{2'h0, ~dst_req[i].addr};
                end
            end
        end
    end
endmodule // dte_dst_model

/* verif/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dte_pkg::*;
    logic                 clk, rst, read, write, waitrequest, irq, tmo, ok;
    logic                 primary_system_error_event;
    logic [AV_AW-1:0]     address;
    logic [31:0]          writedata, readdata, rv;
    logic [3:0]           byteenable;
    logic [1:0]           ini_valid, ini_retry, ini_done, dst_valid, dst_ack, dst_timeout;
    logic [7:0]           lat;
    dte_req_t [1:0]       ini_req, dst_req;
    dte_rsp_t [1:0]       ini_rsp, dst_rsp;
    int                   n_errors, checked, n;

    // small discard limit keeps the run brief
    dte_engine #(.DISCARD_LONG(64)) dut (.*);
    dte_dst_model u_dst (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic wrap_up;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string nm);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // avalon access, request held until waitrequest samples low
    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
        int i;
        address <= {ix, 2'b00};
        read <= !w;
        write <= w;
        writedata <= d;
        byteenable <= 4'hf;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (i == 20) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk);
    endtask

    // one initiator attempt; n counts clocks to the answer
    task automatic ini(input int d, input logic [31:0] a, input logic [3:0] c);
        int i;
        ini_req[d] <= '{a, c, 4'hf, ~a};
        ini_valid[d] <= 1'b1;
        @(posedge clk);
        ini_valid[d] <= 1'b0;
        for (i = 1; i < 40; i++) begin
            @(posedge clk);
            if (ini_retry[d] === 1'b1 || ini_done[d] === 1'b1) break;
        end
        n = i;
        ok = ini_done[d];
        if (i == 40) begin
            n_errors++;
            wrap_up();
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {read, write, tmo, rst} = 4'b0001;
        address = '0;
        writedata = '0;
        byteenable = '0;
        ini_valid = '0;
        ini_req = '0;
        lat = 8'h05;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, REG_DIAG_CTRL, 0);
        chk(0, rv, "diag reset");
        bus(0, REG_BRIDGE_CTRL, 0);
        chk(0, rv, "bridge reset");
        bus(0, 8'h10, 0);
        chk(0, rv, "unmapped");
        // retry, then the identical repeat
        ini(0, 32'h1000, 4'h6);
        chk(1, n, "retry delay");
        chk(0, ok, "no data on retry");
        ini(1, 32'h2000, 4'h6);
        chk(1, n, "up retry");
        repeat (12) @(posedge clk);
        bus(0, REG_SLOT_STAT, 0);
        chk(32'hf, rv, "both held");
        ini(0, 32'h1004, 4'h6);
        chk(0, ok, "mismatch");
        ini(0, 32'h1000, 4'h6);
        chk(1, ok, "match");
        chk(~32'h1000, ini_rsp[0].rdata, "read data");
        ini(1, 32'h2000, 4'h6);
        chk(1, ok, "up match");
        bus(0, REG_SLOT_STAT, 0);
        chk(0, rv, "slots free");
        // stale write completion is dropped after 64 clocks
        bus(1, REG_IRQ_EN, 32'h1);
        ini(0, 32'h3000, 4'h7);
        repeat (30) @(posedge clk);
        bus(0, REG_SLOT_STAT, 0);
        chk(32'h3, rv, "held before expiry");
        repeat (60) @(posedge clk);
        bus(0, REG_SLOT_STAT, 0);
        chk(0, rv, "discarded");
        chk(1, irq, "discard irq");
        bus(1, REG_IRQ_CLR, 32'h1);
        chk(0, irq, "irq cleared");
        // destination timeout on a delayed write, then a read
        tmo <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            ini(0, 32'h4000, 4'h7 - k[3:0]);
            ok = 1'b0;
            repeat (12) begin
                @(posedge clk);
                if (primary_system_error_event === 1'b1) ok = 1'b1;
            end
            chk(1, ok, "system error");
        end
        tmo <= 1'b0;
        bus(0, REG_SERR_STAT, 0);
        chk(32'h60, rv, "serr status");
        // waiting mode: done inside 16 clocks, else retry by 16
        bus(1, REG_DIAG_CTRL, 32'h4);
        ini(0, 32'h5000, 4'h6);
        chk(1, ok, "fast done");
        lat <= 8'd16;
        ini(0, 32'h6000, 4'he);
        chk(1, n <= 16, "retry by 16");
        chk(0, ok, "slow retried");
        bus(1, REG_PF_CTRL, 32'h1);
        ini(0, 32'h6004, 4'he);
        chk(1, irq, "prefetch drop");
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule // tb
